// >>> hdl/motion_queue_port.sv
// Serial target with byte queue, identity and accelerometer offset registers
//
// How it works
// - A sample strobe while no frame is in progress pushes enabled bytes of registers 59..72 in ascending order.
// - A source's bytes are queued only if its enable bit is one at the sample strobe.
// - A push into a full queue sets the sticky overflow flag.
// - Mode clear drops oldest byte on overflow; mode set drops the new byte.
// - Reading the data port while empty returns 0xff, count stays.
// - Genuine bytes equal to 0xff are queued as 0xfe instead.
// - Reads of the data port pop, writes to it push host bytes.
// - A read-only identity register returns a fixed code.
// - Target address is 0x68 or 0x69 by the address select pin.
// - Offset high holds bits 14..7, low holds 6..0 in 7..1, bit0 zero.
// - Offsets leave as 15-bit values in 0.98 mg steps for the datapath.
// - Y and Z offset pairs share the X layout at own addresses.
// - A 13-bit level; reading the high byte latches both bytes.
// - Queue data port sits at register address 0x74.
`timescale 1ns/1ps
module motion_queue_port #(
    parameter int         DEPTH   = 512,  // Queue bytes, power of two
    parameter logic [7:0] ID_CODE = 8'h5a // Arbitrary identity value
) (
    input  wire logic                                       clock,               // 200 MHz
    input  wire logic                                       rstn,                // Sync reset
    input  wire logic                                       scl_in,              // Link clock
    input  wire logic                                       sda_in,              // Link data in
    output logic                                            sda_out,             // Always low
    output logic                                            sda_oe,              // Pull low
    input  wire logic                                       address_select_pin,  // Address bit
    input  wire logic                                       sample_strobe,       // Sample pulse
    input  wire logic [queue_port_pkg::SAMPLE_BYTES*8-1:0]  sensor_bytes,        // Reg 59 on top
    input  wire logic [7:0]                                 source_enable,       // Enable flags
    input  wire logic                                       keep_oldest,         // Mode bit
    input  wire logic                                       overflow_clear,      // Clear pulse
    output logic                                            queue_overflow_flag, // Sticky
    output logic [queue_port_pkg::LEVEL_W-1:0]              queue_level,         // Bytes held
    output logic [queue_port_pkg::OFFSET_W-1:0]             accel_x_offset_value, // X offset
    output logic [queue_port_pkg::OFFSET_W-1:0]             accel_y_offset_value, // Y offset
    output logic [queue_port_pkg::OFFSET_W-1:0]             accel_z_offset_value  // Z offset
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || DEPTH > 4096 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_check
        $error("DEPTH must be a power of two from 2 to 4096");
    end

    typedef logic [queue_port_pkg::SAMPLE_BYTES*8-1:0] frame_t;
    typedef logic [queue_port_pkg::LEVEL_W-1:0]        level_t;
    typedef logic [queue_port_pkg::OFFSET_W-1:0]       offset_t;

    localparam level_t FULL_LEVEL = DEPTH[queue_port_pkg::LEVEL_W-1:0];

    typedef struct packed {
        logic                        scl_meta;
        logic                        scl_sync;
        logic                        scl_prev;
        logic                        sda_meta;
        logic                        sda_sync;
        logic                        sda_prev;
        logic                        ad_meta;
        logic                        ad_sync;
        queue_port_pkg::link_state_t link;
        logic [3:0]                  bit_cnt;
        logic [7:0]                  shift;
        logic [7:0]                  tx;
        logic                        rw;
        logic                        first_byte;
        logic [7:0]                  ptr;
        logic                        sda_oe;
        logic                        sda_low;
        logic                        host_pend;
        logic [7:0]                  host_byte;
        logic                        seq_busy;
        logic [3:0]                  seq_idx;
        logic [7:0]                  seq_mask;
        frame_t                      seq_data;
        logic [AW-1:0]               rd_ptr;
        logic [AW-1:0]               wr_ptr;
        level_t                      level;
        level_t                      level_snap;
        logic                        overflow;
        offset_t                     x_off;
        offset_t                     y_off;
        offset_t                     z_off;
    } state_t;

    state_t     s_reg;
    state_t     s_next;
    logic [7:0] mem [DEPTH];
    logic       mem_we;
    logic [7:0] mem_wdata;

    function automatic logic [7:0] clean(input logic [7:0] b);
        return (b == queue_port_pkg::EMPTY_MARKER) ? queue_port_pkg::MARKER_STANDIN : b;
    endfunction

    function automatic logic byte_enabled(input logic [3:0] idx, input logic [7:0] en);
        if (idx <= queue_port_pkg::ACCEL_LAST_IDX) return en[queue_port_pkg::EN_ACCEL_BIT];
        if (idx <= queue_port_pkg::TEMP_LAST_IDX) return en[queue_port_pkg::EN_TEMP_BIT];
        if (idx <= queue_port_pkg::GYRO_X_LAST_IDX) return en[queue_port_pkg::EN_GYRO_X_BIT];
        if (idx <= queue_port_pkg::GYRO_Y_LAST_IDX) return en[queue_port_pkg::EN_GYRO_Y_BIT];
        return en[queue_port_pkg::EN_GYRO_Z_BIT];
    endfunction

    function automatic logic [7:0] sample_byte(input logic [3:0] idx, input frame_t d);
        return d[(queue_port_pkg::SAMPLE_BYTES - 1 - int'(idx)) * 8 +: 8];
    endfunction

    function automatic logic [7:0] reg_read(input state_t s, input logic [7:0] a);
        case (a)
            queue_port_pkg::REG_LEVEL_HIGH: return {3'h0, s.level[12:8]};
            queue_port_pkg::REG_LEVEL_LOW:  return s.level_snap[7:0];
            queue_port_pkg::REG_IDENTITY:   return ID_CODE;
            // offset split, same for Y and Z
            queue_port_pkg::REG_X_OFF_HIGH: return s.x_off[14:7];
            queue_port_pkg::REG_X_OFF_LOW:  return {s.x_off[6:0], 1'h0};
            queue_port_pkg::REG_Y_OFF_HIGH: return s.y_off[14:7];
            queue_port_pkg::REG_Y_OFF_LOW:  return {s.y_off[6:0], 1'h0};
            queue_port_pkg::REG_Z_OFF_HIGH: return s.z_off[14:7];
            queue_port_pkg::REG_Z_OFF_LOW:  return {s.z_off[6:0], 1'h0};
            default:                        return queue_port_pkg::UNMAPPED_VALUE;
        endcase
    endfunction

    always_comb begin
        logic       scl_rise;
        logic       scl_fall;
        logic       start_seen;
        logic       stop_seen;
        logic       do_load;
        logic       pop;
        logic       push;
        logic       full;
        logic       ovf;
        scl_rise   = s_reg.scl_sync & ~s_reg.scl_prev;
        scl_fall   = ~s_reg.scl_sync & s_reg.scl_prev;
        start_seen = s_reg.scl_sync & s_reg.scl_prev & s_reg.sda_prev & ~s_reg.sda_sync;
        stop_seen  = s_reg.scl_sync & s_reg.scl_prev & ~s_reg.sda_prev & s_reg.sda_sync;
        full       = (s_reg.level == FULL_LEVEL);
        do_load    = 1'b0;
        pop        = 1'b0;
        push       = 1'b0;
        ovf        = 1'b0;
        mem_we     = 1'b0;
        mem_wdata  = 8'h00;
        s_next     = s_reg;

        s_next.scl_meta = scl_in;
        s_next.scl_sync = s_reg.scl_meta;
        s_next.scl_prev = s_reg.scl_sync;
        s_next.sda_meta = sda_in;
        s_next.sda_sync = s_reg.sda_meta;
        s_next.sda_prev = s_reg.sda_sync;
        s_next.ad_meta  = address_select_pin;
        s_next.ad_sync  = s_reg.ad_meta;

        if (start_seen) begin
            s_next.link    = queue_port_pkg::LINK_ADDR;
            s_next.bit_cnt = 4'h0;
            s_next.sda_oe  = 1'b0;
        end else if (stop_seen) begin
            s_next.link   = queue_port_pkg::LINK_IDLE;
            s_next.sda_oe = 1'b0;
        end else begin
            case (s_reg.link)
                queue_port_pkg::LINK_ADDR, queue_port_pkg::LINK_WRITE: begin
                    if (scl_rise) begin
                        s_next.shift   = {s_reg.shift[6:0], s_reg.sda_sync};
                        s_next.bit_cnt = s_reg.bit_cnt + 4'h1;
                    end else if (scl_fall && s_reg.bit_cnt == queue_port_pkg::BYTE_BITS) begin
                        if (s_reg.link == queue_port_pkg::LINK_ADDR) begin
                            // address select pin sets low bit
                            if (s_reg.shift[7:1] ==
                                {queue_port_pkg::TARGET_ADDR[6:1], s_reg.ad_sync}) begin
                                s_next.sda_oe     = 1'b1;
                                s_next.rw         = s_reg.shift[0];
                                s_next.first_byte = 1'b1;
                                s_next.link       = queue_port_pkg::LINK_ACK_ADDR;
                            end else begin
                                s_next.link = queue_port_pkg::LINK_IDLE;
                            end
                        end else begin
                            s_next.sda_oe = 1'b1;
                            s_next.link   = queue_port_pkg::LINK_ACK_WRITE;
                            if (s_reg.first_byte) begin
                                s_next.ptr        = s_reg.shift;
                                s_next.first_byte = 1'b0;
                            end else begin
                                case (s_reg.ptr)
                                    queue_port_pkg::REG_QUEUE_DATA: begin
                                        s_next.host_pend = 1'b1;
                                        s_next.host_byte = clean(s_reg.shift);
                                    end
                                    queue_port_pkg::REG_X_OFF_HIGH: s_next.x_off[14:7] = s_reg.shift;
                                    queue_port_pkg::REG_X_OFF_LOW:  s_next.x_off[6:0] = s_reg.shift[7:1];
                                    queue_port_pkg::REG_Y_OFF_HIGH: s_next.y_off[14:7] = s_reg.shift;
                                    queue_port_pkg::REG_Y_OFF_LOW:  s_next.y_off[6:0] = s_reg.shift[7:1];
                                    queue_port_pkg::REG_Z_OFF_HIGH: s_next.z_off[14:7] = s_reg.shift;
                                    queue_port_pkg::REG_Z_OFF_LOW:  s_next.z_off[6:0] = s_reg.shift[7:1];
                                    default: ;
                                endcase
                                if (s_reg.ptr != queue_port_pkg::REG_QUEUE_DATA) begin
                                    s_next.ptr = s_reg.ptr + 8'h01;
                                end
                            end
                        end
                    end
                end
                queue_port_pkg::LINK_ACK_ADDR: begin
                    if (scl_fall) begin
                        if (s_reg.rw) begin
                            do_load = 1'b1;
                        end else begin
                            s_next.sda_oe  = 1'b0;
                            s_next.bit_cnt = 4'h0;
                            s_next.link    = queue_port_pkg::LINK_WRITE;
                        end
                    end
                end
                queue_port_pkg::LINK_ACK_WRITE: begin
                    if (scl_fall) begin
                        s_next.sda_oe  = 1'b0;
                        s_next.bit_cnt = 4'h0;
                        s_next.link    = queue_port_pkg::LINK_WRITE;
                    end
                end
                queue_port_pkg::LINK_READ: begin
                    if (scl_fall) begin
                        if (s_reg.bit_cnt == queue_port_pkg::LAST_TX_BIT) begin
                            s_next.sda_oe = 1'b0;
                            s_next.link   = queue_port_pkg::LINK_ACK_READ;
                        end else begin
                            s_next.bit_cnt = s_reg.bit_cnt + 4'h1;
                            s_next.tx      = {s_reg.tx[6:0], 1'b0};
                            s_next.sda_oe  = ~s_reg.tx[6];
                        end
                    end
                end
                queue_port_pkg::LINK_ACK_READ: begin
                    if (scl_rise && s_reg.sda_sync) begin
                        s_next.link = queue_port_pkg::LINK_IDLE;
                    end else if (scl_fall) begin
                        do_load = 1'b1;
                    end
                end
                default: ;
            endcase
        end

        if (do_load) begin
            if (s_reg.ptr == queue_port_pkg::REG_QUEUE_DATA) begin
                // empty marker, pop only when data held
                if (s_reg.level != '0) begin
                    s_next.tx = mem[s_reg.rd_ptr];
                    pop       = 1'b1;
                end else begin
                    s_next.tx = queue_port_pkg::EMPTY_MARKER;
                end
            end else begin
                s_next.tx  = reg_read(s_reg, s_reg.ptr);
                s_next.ptr = s_reg.ptr + 8'h01;
                if (s_reg.ptr == queue_port_pkg::REG_LEVEL_HIGH) begin
                    s_next.level_snap = s_reg.level;
                end
            end
            s_next.sda_oe  = ~s_next.tx[7];
            s_next.bit_cnt = 4'h0;
            s_next.link    = queue_port_pkg::LINK_READ;
        end

        if (s_reg.host_pend) begin
            push             = 1'b1;
            mem_wdata        = s_reg.host_byte;
            s_next.host_pend = 1'b0;
        end else if (s_reg.seq_busy) begin
            // one byte per cycle in register order
            push           = byte_enabled(s_reg.seq_idx, s_reg.seq_mask);
            mem_wdata      = clean(sample_byte(s_reg.seq_idx, s_reg.seq_data));
            s_next.seq_idx = s_reg.seq_idx + 4'h1;
            if (s_reg.seq_idx == queue_port_pkg::LAST_SAMPLE_IDX) begin
                s_next.seq_busy = 1'b0;
            end
        end
        if (!s_reg.seq_busy && sample_strobe) begin
            s_next.seq_busy = 1'b1;
            s_next.seq_idx  = 4'h0;
            s_next.seq_mask = source_enable;
            s_next.seq_data = sensor_bytes;
        end

        if (pop) begin
            s_next.rd_ptr = s_reg.rd_ptr + 1'b1;
        end
        if (push) begin
            if (!full || pop) begin
                mem_we        = 1'b1;
                s_next.wr_ptr = s_reg.wr_ptr + 1'b1;
            end else begin
                ovf = 1'b1;
                // mode chooses which byte is lost
                if (!keep_oldest) begin
                    mem_we        = 1'b1;
                    s_next.wr_ptr = s_reg.wr_ptr + 1'b1;
                    s_next.rd_ptr = s_reg.rd_ptr + 1'b1;
                end
            end
        end
        // level tracks pops and accepted pushes
        if (pop && !push) begin
            s_next.level = s_reg.level - 1'b1;
        end else if (push && !pop && !full) begin
            s_next.level = s_reg.level + 1'b1;
        end
        s_next.overflow = (s_reg.overflow & ~overflow_clear) | ovf;
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    always_ff @(posedge clock) begin
        if (mem_we) begin
            mem[s_reg.wr_ptr] <= mem_wdata;
        end
    end

    assign sda_out              = s_reg.sda_low;
    assign sda_oe               = s_reg.sda_oe;
    assign queue_overflow_flag  = s_reg.overflow;
    assign queue_level          = s_reg.level;
    assign accel_x_offset_value = s_reg.x_off;
    assign accel_y_offset_value = s_reg.y_off;
    assign accel_z_offset_value = s_reg.z_off;
endmodule // motion_queue_port

// >>> hdl/queue_port_pkg.sv
// Constants for the motion sensor queue port, identity and offset registers
package queue_port_pkg;
    // Register addresses
    localparam logic [7:0] REG_LEVEL_HIGH  = 8'h72;
    localparam logic [7:0] REG_LEVEL_LOW   = 8'h73;
    localparam logic [7:0] REG_QUEUE_DATA  = 8'h74;
    localparam logic [7:0] REG_IDENTITY    = 8'h75;
    localparam logic [7:0] REG_X_OFF_HIGH  = 8'h77;
    localparam logic [7:0] REG_X_OFF_LOW   = 8'h78;
    localparam logic [7:0] REG_Y_OFF_HIGH  = 8'h7a;
    localparam logic [7:0] REG_Y_OFF_LOW   = 8'h7b;
    localparam logic [7:0] REG_Z_OFF_HIGH  = 8'h7d;
    localparam logic [7:0] REG_Z_OFF_LOW   = 8'h7e;
    localparam logic [7:0] UNMAPPED_VALUE  = 8'h00;
    // Link target address
    localparam logic [6:0] TARGET_ADDR     = 7'h68;
    // Empty marker and stand-in
    localparam logic [7:0] EMPTY_MARKER    = 8'hff;
    localparam logic [7:0] MARKER_STANDIN  = 8'hfe;
    // Sample frame: registers 59 to 72, fourteen bytes
    localparam int         SAMPLE_BYTES    = 14;
    localparam logic [3:0] LAST_SAMPLE_IDX = 4'hd;
    // Last byte index of each source
    localparam logic [3:0] ACCEL_LAST_IDX  = 4'h5;
    localparam logic [3:0] TEMP_LAST_IDX   = 4'h7;
    localparam logic [3:0] GYRO_X_LAST_IDX = 4'h9;
    localparam logic [3:0] GYRO_Y_LAST_IDX = 4'hb;
    // Source enable bit positions
    localparam int         EN_TEMP_BIT     = 7;
    localparam int         EN_GYRO_X_BIT   = 6;
    localparam int         EN_GYRO_Y_BIT   = 5;
    localparam int         EN_GYRO_Z_BIT   = 4;
    localparam int         EN_ACCEL_BIT    = 3;
    // Field layout of offsets and level
    localparam int         LEVEL_W         = 13;
    localparam int         OFFSET_W        = 15;
    localparam logic [3:0] BYTE_BITS       = 4'h8;
    localparam logic [3:0] LAST_TX_BIT     = 4'h7;
    typedef enum logic [2:0] {
        LINK_IDLE, LINK_ADDR, LINK_ACK_ADDR, LINK_WRITE, LINK_ACK_WRITE, LINK_READ,
        LINK_ACK_READ
    } link_state_t;
endpackage

// >>> tb/motion_queue_port_assertions.sv
// Checker of queue level, overflow flag and X and Y offset ports
`timescale 1ns/1ps
module motion_queue_port_assertions #(
    parameter int DEPTH = 512 // Queue bytes
) (
    input wire logic         clock, // Clock
    input wire logic         rstn, // Reset
    input wire logic         scl_in, // Link clock
    input wire logic         sda_in, // Link data
    input wire logic         sda_out, // Data out
    input wire logic         sda_oe, // Pull low
    input wire logic         address_select_pin, // Address bit
    input wire logic         sample_strobe, // Sample pulse
    input wire logic [111:0] sensor_bytes, // Sample bytes
    input wire logic [7:0]   source_enable, // Enables
    input wire logic         keep_oldest, // Mode
    input wire logic         overflow_clear, // Clear
    input wire logic         queue_overflow_flag, // Flag
    input wire logic [12:0]  queue_level, // Level
    input wire logic [14:0]  accel_x_offset_value, // X offset
    input wire logic [14:0]  accel_y_offset_value, // Y offset
    input wire logic [14:0]  accel_z_offset_value // Z offset
);
    // Cycles since the last strobe, saturating
    logic [4:0] since_reg;
    always_ff @(posedge clock) begin
        if (!rstn || sample_strobe) since_reg <= 5'h00;
        else if (since_reg != 5'h1f) since_reg <= since_reg + 5'h01;
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    sequence s_idle_strobe;
        sample_strobe && since_reg > 5'h13 && queue_level == 13'h0 && scl_in && sda_in;
    endsequence
    property p_frame_full;
        s_idle_strobe ##0 source_enable[7:3] == 5'h1f |-> ##[14:18] queue_level == 13'he;
    endproperty
    property p_frame_off;
        s_idle_strobe ##0 source_enable[7:3] == 5'h00
            |=> (queue_level == 13'h0) [*8] ##1 (queue_level == 13'h0) [*8];
    endproperty
    property p_flag_full;
        $rose(queue_overflow_flag) |-> ##[0:1] queue_level == DEPTH;
    endproperty
    property p_flag_sticky;
        queue_overflow_flag && !overflow_clear |=> queue_overflow_flag;
    endproperty
    property p_level_bound;
        queue_level <= DEPTH;
    endproperty
    property p_level_step;
        $past(rstn) && !$stable(queue_level) |-> queue_level == $past(queue_level) + 13'h1
            || queue_level == $past(queue_level) - 13'h1;
    endproperty
    property p_x_split;
        $past(rstn) |-> $stable(accel_x_offset_value[14:7]) || $stable(accel_x_offset_value[6:0]);
    endproperty
    property p_y_split;
        $past(rstn) |-> $stable(accel_y_offset_value[14:7]) || $stable(accel_y_offset_value[6:0]);
    endproperty
    a_frame_full: assert property (p_frame_full) else $error("frame not queued whole");
    a_frame_off: assert property (p_frame_off) else $error("disabled bytes queued");
    a_flag_full: assert property (p_flag_full) else $error("flag set while not full");
    a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped");
    a_level_bound: assert property (p_level_bound) else $error("level above depth");
    a_level_step: assert property (p_level_step) else $error("level jumped");
    a_x_split: assert property (p_x_split) else $error("x halves changed together");
    a_y_split: assert property (p_y_split) else $error("y halves changed together");
endmodule // motion_queue_port_assertions
bind motion_queue_port motion_queue_port_assertions #(.DEPTH(DEPTH)) u_motion_queue_port_assertions (
    .clock(clock), .rstn(rstn), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .address_select_pin(address_select_pin), .sample_strobe(sample_strobe),
    .sensor_bytes(sensor_bytes), .source_enable(source_enable), .keep_oldest(keep_oldest),
    .overflow_clear(overflow_clear), .queue_overflow_flag(queue_overflow_flag),
    .queue_level(queue_level), .accel_x_offset_value(accel_x_offset_value),
    .accel_y_offset_value(accel_y_offset_value), .accel_z_offset_value(accel_z_offset_value));

// >>> tb/i2c_host_model.sv
// Link host model driving the link clock and open-drain data
`timescale 1ns/1ps
module i2c_host_model (
    input wire logic sda_wire, // Data wire level
    output logic     scl,      // Link clock
    output logic     sda_rel   // High releases data
);
    initial begin
        scl = 1'b1;
        sda_rel = 1'b1;
    end
    task automatic start();
        #16 sda_rel = 1'b1;
        #16 scl = 1'b1;
        #16 sda_rel = 1'b0;
        #16 scl = 1'b0;
    endtask
    task automatic stop();
        #16 sda_rel = 1'b0;
        #16 scl = 1'b1;
        #16 sda_rel = 1'b1;
        #16;
    endtask
    task automatic bit_io(input logic b, output logic r);
        #16 sda_rel = b;
        #16 scl = 1'b1;
        #16 r = sda_wire;
        #16 scl = 1'b0;
    endtask
    // byte out and in, then ack bit
    task automatic byte_io(input logic [7:0] tx, input logic a, output logic [7:0] rx,
                           output logic ack);
        for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
        bit_io(a, ack);
    endtask
endmodule // i2c_host_model

// >>> tb/motion_queue_port_tb.sv
// Self-checking bench of the queue port, identity and offset registers
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
$display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module motion_queue_port_tb;
    localparam int           DEPTH = 16;
    localparam logic [7:0]   ID    = 8'h3c; // Arbitrary identity value
    localparam logic [111:0] PAT_A = 112'h1011ff131415161718191a1b1c1d;
    localparam logic [111:0] PAT_B = 112'h404142434445464748494a4b4c4d;
    logic         clock = 1'b0, rstn = 1'b0, pin = 1'b0, strobe = 1'b0, keep = 1'b0, oclr = 1'b0;
    logic [111:0] sbytes = 112'h0;
    logic [7:0]   en = 8'h00;
    logic         scl, sda_rel, sda_oe, flag, ack;
    logic [12:0]  level;
    logic [14:0]  xo, yo, zo;
    logic [6:0]   tgt;
    logic [7:0]   p;
    logic [7:0]   rx [16];
    logic [7:0]   exp_q [$];
    int           mismatches = 0;
    int           n_tests = 0;
    wire          sda = sda_rel & ~sda_oe;
    always #2.5 clock = ~clock;
    motion_queue_port #(.DEPTH(DEPTH), .ID_CODE(ID)) u_motion_queue_port (
        .clock(clock), .rstn(rstn), .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe(sda_oe),
        .address_select_pin(pin), .sample_strobe(strobe), .sensor_bytes(sbytes),
        .source_enable(en), .keep_oldest(keep), .overflow_clear(oclr),
        .queue_overflow_flag(flag), .queue_level(level), .accel_x_offset_value(xo),
        .accel_y_offset_value(yo), .accel_z_offset_value(zo));
    i2c_host_model u_i2c_host_model (.sda_wire(sda), .scl(scl), .sda_rel(sda_rel));
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] r;
        u_i2c_host_model.start();
        u_i2c_host_model.byte_io({tgt, 1'b0}, 1'b1, r, ack);
        u_i2c_host_model.byte_io(a, 1'b1, r, ack);
        u_i2c_host_model.byte_io(d, 1'b1, r, ack);
        u_i2c_host_model.stop();
    endtask
    task automatic rd(input logic [7:0] a, input int n);
        logic [7:0] r;
        logic       k;
        u_i2c_host_model.start();
        u_i2c_host_model.byte_io({tgt, 1'b0}, 1'b1, r, ack);
        u_i2c_host_model.byte_io(a, 1'b1, r, k);
        u_i2c_host_model.start();
        u_i2c_host_model.byte_io({tgt, 1'b1}, 1'b1, r, k);
        for (int i = 0; i < n; i++) u_i2c_host_model.byte_io(8'hff, i == n - 1, rx[i], k);
        u_i2c_host_model.stop();
    endtask
    function automatic void push(input logic [7:0] v);
        if (exp_q.size() < DEPTH) exp_q.push_back(v);
        else if (!keep) begin
            void'(exp_q.pop_front());
            exp_q.push_back(v);
        end
    endfunction
    task automatic frame(input logic [111:0] b, input logic [7:0] e);
        logic [7:0] v;
        @(posedge clock);
        sbytes <= b;
        en <= e;
        strobe <= 1'b1;
        @(posedge clock);
        strobe <= 1'b0;
        for (int k = 0; k < 14; k++) begin
            v = b[111 - 8 * k -: 8];
            if (e[k < 6 ? 3 : k < 8 ? 7 : k < 10 ? 6 : k < 12 ? 5 : 4])
                push(v === 8'hff ? 8'hfe : v);
        end
        repeat (20) @(posedge clock);
    endtask
    task automatic drain(input int n);
        logic [7:0] e;
        rd(queue_port_pkg::REG_QUEUE_DATA, n);
        for (int i = 0; i < n; i++) begin
            e = exp_q.size() > 0 ? exp_q.pop_front() : queue_port_pkg::EMPTY_MARKER;
            `CHK(rx[i], e)
        end
        `CHK(level, 13'(exp_q.size()))
    endtask
    task automatic end_of_test();
        if (mismatches == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge clock);
        mismatches++;
        end_of_test();
    end
    initial begin
        tgt = queue_port_pkg::TARGET_ADDR;
        repeat (10) @(posedge clock);
        rstn <= 1'b1;
        repeat (5) @(posedge clock);
        wr(queue_port_pkg::REG_IDENTITY, 8'h00);
        rd(queue_port_pkg::REG_IDENTITY, 2);
        `CHK(rx[0], ID)
        `CHK(rx[1], queue_port_pkg::UNMAPPED_VALUE)
        drain(1);
        for (int a = 0; a < 3; a++) begin
            p = queue_port_pkg::REG_X_OFF_HIGH + 8'(3 * a);
            wr(p, 8'h81 + 8'(a));
            wr(p + 8'h01, 8'h5b + 8'(a));
            rd(p, 2);
            `CHK(rx[0], 8'h81 + 8'(a))
            `CHK(rx[1], (8'h5b + 8'(a)) & 8'hfe)
        end
        `CHK(xo, {8'h81, 7'h2d})
        `CHK(yo, {8'h82, 7'h2e})
        `CHK(zo, {8'h83, 7'h2e})
        frame(PAT_A, 8'h00);
        `CHK(level, 13'h0)
        frame(PAT_A, 8'h18);
        rd(queue_port_pkg::REG_LEVEL_HIGH, 2);
        `CHK({rx[0], rx[1]}, 16'h0008)
        drain(9);
        wr(queue_port_pkg::REG_QUEUE_DATA, 8'h42);
        push(8'h42);
        wr(queue_port_pkg::REG_QUEUE_DATA, 8'hff);
        push(8'hfe);
        drain(2);
        for (int m = 0; m < 2; m++) begin
            frame(PAT_A, 8'hf8);
            frame(PAT_B, 8'hf8);
            `CHK(flag, 1'b1)
            drain(16);
            @(posedge clock);
            oclr <= 1'b1;
            keep <= 1'b1;
            @(posedge clock);
            oclr <= 1'b0;
            @(posedge clock);
            `CHK(flag, 1'b0)
        end
        pin <= 1'b1;
        repeat (5) @(posedge clock);
        rd(queue_port_pkg::REG_IDENTITY, 1);
        `CHK(ack, 1'b1)
        tgt = queue_port_pkg::TARGET_ADDR | 7'h01;
        rd(queue_port_pkg::REG_IDENTITY, 1);
        `CHK({ack, rx[0]}, {1'b0, ID})
        end_of_test();
    end
endmodule // motion_queue_port_tb
